// File: logic/dtc_top.sv
// dual timer counter with pwm output and axi4-lite register slave
`timescale 1ns/1ns
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [dtc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [dtc_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      capture_trigger_zero,
  input  wire logic                      capture_trigger_one,
  input  wire logic                      freeze,
  output logic                           generate_out_zero,
  output logic                           generate_out_one,
  output logic                           pulse_width_output,
  output logic                           interrupt
);
  import dtc_pkg::*;

  // -------------------------------------------------------------------------
  // state record
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic             aw_got;     // write address held
    logic             w_got;      // write data held
    logic [ADDR_W-1:0] aw_addr;   // latched write address
    logic [DATA_W-1:0] w_data;    // latched write data
    logic             bvalid;     // write response pending
    logic             rvalid;     // read data pending
    logic [DATA_W-1:0] rdata;     // read data
    logic [1:0][CSR_W-1:0] csr;   // control/status per timer
    logic [1:0][CNT_W-1:0] load;  // load registers
    logic [1:0][CNT_W-1:0] cnt;   // counters
    logic [1:0]       held;       // counter parked after a hold rollover
    logic [1:0][2:0]  cap_sync;   // two-flop sync plus edge history
    logic [2:0]       frz_sync;   // freeze synchroniser
    logic [1:0]       gen;        // generate outputs
    logic             pwm;        // pwm output
    logic             irq;        // interrupt output
  } dtc_state_t;

  dtc_state_t st_ff;   // registered state
  dtc_state_t nxt_st;  // next state

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // step a counter one place up or down
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v, input logic dn);
    step = dn ? v - CNT_W'(1) : v + CNT_W'(1);
  endfunction

  // wrap condition: all ones going up, all zeros going down
  function automatic logic at_wrap(input logic [CNT_W-1:0] v, input logic dn);
    at_wrap = dn ? (v == '0) : (v == '1);
  endfunction

  // read mux for one address
  function automatic logic [DATA_W-1:0] rd_mux(input dtc_state_t s, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = '0;
    if (a == OFF_CSR0) begin
      d = DATA_W'(s.csr[0]);
    end else if (a == OFF_LOAD0) begin
      d = s.load[0];
    end else if (a == OFF_CNT0) begin
      d = s.cnt[0];
    end else if (a == OFF_CSR1) begin
      d = DATA_W'(s.csr[1]);
    end else if (a == OFF_LOAD1) begin
      d = s.load[1];
    end else if (a == OFF_CNT1) begin
      d = s.cnt[1];
    end
    rd_mux = d;  // unused addresses read zero
  endfunction

  // -------------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------------
  logic             casc;       // cascade active
  logic             frz;        // synchronised freeze
  logic [1:0]       run;        // timer enabled and free to count
  logic [1:0]       cap_ev;     // qualified capture edge
  logic [1:0]       wrap;       // counter rollover this cycle
  logic [1:0]       ev;         // interrupt condition
  logic             wr_fire;    // write commits this cycle
  logic [1:0]       wr_csr;     // write hits a control register
  logic [1:0]       ctl_dn;     // effective direction
  logic [1:0]       ctl_mode;   // effective mode
  logic [1:0]       ctl_arh;    // effective auto reload

  always_comb begin
    nxt_st = st_ff;
    // ---- synchronisers on pins
    nxt_st.frz_sync = {st_ff.frz_sync[1:0], freeze};
    nxt_st.cap_sync[0] = {st_ff.cap_sync[0][1:0], capture_trigger_zero};
    nxt_st.cap_sync[1] = {st_ff.cap_sync[1][1:0], capture_trigger_one};
    frz = st_ff.frz_sync[1];
    casc = st_ff.csr[0][B_CASC];
    // in cascade timer one borrows timer zero's controls
    for (int i = 0; i < 2; i++) begin
      ctl_dn[i]   = (casc ? st_ff.csr[0][B_DIR]  : st_ff.csr[i][B_DIR]);
      ctl_mode[i] = (casc ? st_ff.csr[0][B_MODE] : st_ff.csr[i][B_MODE]);
      ctl_arh[i]  = (casc ? st_ff.csr[0][B_ARH]  : st_ff.csr[i][B_ARH]);
      run[i] = (casc ? st_ff.csr[0][B_EN] & ~st_ff.csr[0][B_LOAD] & ~st_ff.held[0]
                     : st_ff.csr[i][B_EN] & ~st_ff.csr[i][B_LOAD] & ~st_ff.held[i])
               & ~frz;
    end
    // capture edge from second sync stage; timer one trigger unused in cascade
    cap_ev[0] = st_ff.cap_sync[0][1] & ~st_ff.cap_sync[0][2] & st_ff.csr[0][B_CAP]
                & run[0] & ctl_mode[0];
    cap_ev[1] = ~casc & st_ff.cap_sync[1][1] & ~st_ff.cap_sync[1][2]
                & st_ff.csr[1][B_CAP] & run[1] & ctl_mode[1];
    // a parked counter rearms on load or when disabled
    for (int i = 0; i < 2; i++) begin
      if (st_ff.csr[i][B_LOAD] || !st_ff.csr[i][B_EN]) begin
        nxt_st.held[i] = 1'b0;
      end
    end
    // counters, stepping every bus clock
    wrap[0] = run[0] & at_wrap(st_ff.cnt[0], ctl_dn[0]);
    wrap[1] = casc ? wrap[0] & at_wrap(st_ff.cnt[1], ctl_dn[0])
                   : run[1] & at_wrap(st_ff.cnt[1], ctl_dn[1]);
    for (int i = 0; i < 2; i++) begin
      if (st_ff.csr[i][B_LOAD] && !(casc && i == 1)) begin
        nxt_st.cnt[i] = st_ff.load[i];  // load bit copies load register
        if (casc) begin
          nxt_st.cnt[1] = st_ff.load[1];
        end
      end else if (casc && i == 1) begin
        if (wrap[0]) begin
          nxt_st.cnt[1] = (wrap[1] && !ctl_mode[0] && !ctl_arh[0]) ? st_ff.cnt[1]
                        : (wrap[1] && !ctl_mode[0]) ? st_ff.load[1]
                        : step(st_ff.cnt[1], ctl_dn[0]);
        end
      end else if (run[i]) begin
        if (casc ? wrap[1] : wrap[i]) begin
          // generate mode rollover: hold or reload
          if (!ctl_mode[i]) begin
            if (ctl_arh[i]) begin
              nxt_st.cnt[i] = st_ff.load[i];
            end else begin
              // hold: stay at the terminal value and stop, so one event only
              nxt_st.held[i] = 1'b1;
            end
          end else begin
            nxt_st.cnt[i] = step(st_ff.cnt[i], ctl_dn[i]);
          end
        end else begin
          nxt_st.cnt[i] = step(st_ff.cnt[i], ctl_dn[i]);
        end
      end
    end
    // interrupt condition per timer
    ev[0] = casc ? ((wrap[1] & ~ctl_mode[0]) | cap_ev[0]) : ((wrap[0] & ~ctl_mode[0]) | cap_ev[0]);
    ev[1] = ~casc & ((wrap[1] & ~ctl_mode[1]) | cap_ev[1]);
    // capture into load register
    for (int i = 0; i < 2; i++) begin
      if (cap_ev[i] && (ctl_arh[i] || !st_ff.csr[i][B_INT])) begin
        nxt_st.load[i] = st_ff.cnt[i];
        if (casc) begin
          nxt_st.load[1] = st_ff.cnt[1];  // high half captured alongside
        end
      end
    end
    // generate outputs, one-cycle pulses
    nxt_st.gen[0] = ev[0] & ~ctl_mode[0] & st_ff.csr[0][B_GEN];
    nxt_st.gen[1] = casc ? wrap[0] & st_ff.csr[0][B_GEN]
                         : ev[1] & ~ctl_mode[1] & st_ff.csr[1][B_GEN];
    // pwm: period wrap of timer zero sets, timer one wrap clears
    if (!(st_ff.csr[0][B_PWM] && st_ff.csr[0][B_EN] && st_ff.csr[1][B_EN])) begin
      nxt_st.pwm = 1'b0;
    end else if (wrap[0]) begin
      nxt_st.pwm = 1'b1;
    end else if (wrap[1]) begin
      nxt_st.pwm = 1'b0;
    end
    // ---- write channel: accept address and data in either order
    nxt_st.aw_got = st_ff.aw_got | s_axi_awvalid;
    nxt_st.w_got  = st_ff.w_got | s_axi_wvalid;
    if (!st_ff.aw_got && s_axi_awvalid) begin
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (!st_ff.w_got && s_axi_wvalid) begin
      nxt_st.w_data = s_axi_wdata;
    end
    wr_fire = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
    for (int i = 0; i < 2; i++) begin
      wr_csr[i] = wr_fire && st_ff.aw_addr == (i == 0 ? OFF_CSR0 : OFF_CSR1);
    end
    if (wr_fire) begin
      nxt_st.bvalid = 1'b1;
      if (st_ff.aw_addr == OFF_LOAD0) begin
        nxt_st.load[0] = st_ff.w_data;
      end else if (st_ff.aw_addr == OFF_LOAD1) begin
        nxt_st.load[1] = st_ff.w_data;
      end
      // control words are written below; other addresses have no effect
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
    end
    // ---- control registers with enable-all and flag clear
    for (int i = 0; i < 2; i++) begin
      if (wr_csr[i]) begin
        nxt_st.csr[i][B_DIR:B_MODE]   = st_ff.w_data[B_DIR:B_MODE];
        nxt_st.csr[i][B_EN:B_GEN]     = st_ff.w_data[B_EN:B_GEN];
        nxt_st.csr[i][B_PWM]          = st_ff.w_data[B_PWM];
        nxt_st.csr[i][B_CASC]         = (i == 0) ? st_ff.w_data[B_CASC] : 1'b0;
        if (st_ff.w_data[B_INT]) begin
          nxt_st.csr[i][B_INT] = 1'b0;  // write one clears
        end
      end
      if (ev[i]) begin
        nxt_st.csr[i][B_INT] = 1'b1;  // set wins over clear
      end
    end
    // enable-all is mirrored; writing one sets both enables
    if (wr_csr[0] || wr_csr[1]) begin
      nxt_st.csr[0][B_ALL] = st_ff.w_data[B_ALL];
      nxt_st.csr[1][B_ALL] = st_ff.w_data[B_ALL];
      if (st_ff.w_data[B_ALL]) begin
        nxt_st.csr[0][B_EN] = 1'b1;
        nxt_st.csr[1][B_EN] = 1'b1;
      end
    end
    // ---- read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end else if (!st_ff.rvalid && s_axi_arvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_mux(st_ff, s_axi_araddr);
    end
    // combined interrupt, gated by enable; timer one flag also masked in cascade
    nxt_st.irq = (nxt_st.csr[0][B_INT] & nxt_st.csr[0][B_IEN])
               | (nxt_st.csr[1][B_INT] & nxt_st.csr[1][B_IEN] & ~nxt_st.csr[0][B_CASC]);
  end

  // -------------------------------------------------------------------------
  // state register with synchronous reset
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;  // clears control, load, counters, outputs
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------------
  // outputs straight from flops
  // -------------------------------------------------------------------------
  assign s_axi_awready      = ~st_ff.aw_got;
  assign s_axi_wready       = ~st_ff.w_got;
  assign s_axi_bvalid       = st_ff.bvalid;
  assign s_axi_bresp        = RESP_OKAY;
  assign s_axi_arready      = ~st_ff.rvalid;
  assign s_axi_rvalid       = st_ff.rvalid;
  assign s_axi_rdata        = st_ff.rdata;
  assign s_axi_rresp        = RESP_OKAY;
  assign generate_out_zero  = st_ff.gen[0];
  assign generate_out_one   = st_ff.gen[1];
  assign pulse_width_output = st_ff.pwm;
  assign interrupt          = st_ff.irq;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  gen_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    generate_out_zero |=> !generate_out_zero || $past(wrap[0]))
    else $error("generate output not a single pulse");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_csr[0] && st_ff.w_data[B_INT] && !ev[0]) |=> !st_ff.csr[0][B_INT])
    else $error("flag not cleared by write one");
  flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.csr[0][B_INT] && !(wr_csr[0] && st_ff.w_data[B_INT])) |=> st_ff.csr[0][B_INT])
    else $error("flag lost without clear");
  irq_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.csr[0][B_INT] && st_ff.csr[0][B_IEN]) |-> interrupt)
    else $error("interrupt output missing");
  freeze_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (frz && !st_ff.csr[0][B_LOAD]) |=> st_ff.cnt[0] == $past(st_ff.cnt[0]))
    else $error("counter moved while frozen");
  count_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run[0] && !casc && !ctl_dn[0] && !wrap[0]) |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 1)
    else $error("counter did not step up");
  capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap_ev[0] && ctl_arh[0] && !wr_fire) |=> st_ff.load[0] == $past(st_ff.cnt[0]) ##0 st_ff.csr[0][B_INT])
    else $error("capture not stored");
  unmapped_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h0c) |=> s_axi_rdata == '0)
    else $error("unmapped read not zero");
  enable_all_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_csr[1] && st_ff.w_data[B_ALL]) |=> st_ff.csr[0][B_EN] && st_ff.csr[1][B_EN])
    else $error("enable-all did not set enables");
  // hold parks the counter after one rollover
  hold_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wrap[0] && !casc && !ctl_mode[0] && !ctl_arh[0]) |=> st_ff.cnt[0] == $past(st_ff.cnt[0]))
    else $error("held counter moved");
  // auto reload restarts from the load word
  counter_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wrap[0] && !casc && !ctl_mode[0] && ctl_arh[0] && !wr_fire)
    |=> st_ff.cnt[0] == st_ff.load[0])
    else $error("counter not reloaded");
  // every timer zero interrupt condition raises its flag
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[0] |=> st_ff.csr[0][B_INT])
    else $error("flag not set on event");
  // enabled generate output follows a rollover
  gen_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev[0] && !ctl_mode[0] && st_ff.csr[0][B_GEN]) |=> generate_out_zero)
    else $error("generate pulse missing");
  // upper half steps on a lower wrap
  casc_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (casc && wrap[0] && !wrap[1] && !ctl_dn[0]) |=> st_ff.cnt[1] == $past(st_ff.cnt[1]) + 1)
    else $error("upper half did not step");
  // pwm period starts on timer zero wrap
  pwm_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.csr[0][B_PWM] && st_ff.csr[0][B_EN] && st_ff.csr[1][B_EN] && wrap[0])
    |=> pulse_width_output)
    else $error("pwm output did not rise");
  // masked flags keep the output low
  ien_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_ff.csr[0][B_IEN] && !st_ff.csr[1][B_IEN]) |-> !interrupt)
    else $error("interrupt output not masked");
  // load bit copies the load word
  load_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.csr[0][B_LOAD] |=> st_ff.cnt[0] == $past(st_ff.load[0]))
    else $error("load bit did not copy");
  // reset drops every timer output
  rst_clear_a: assert property (@(posedge aclk)
    !aresetn |=> !(interrupt || pulse_width_output || generate_out_zero || generate_out_one))
    else $error("output high after reset");
endmodule

// File: logic/dtc_pkg.sv
// package of constants for the dual timer counter with pwm
package dtc_pkg;
  // -------------------------------------------------------------------------
  // bus geometry
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 5;  // byte address bits decoded
  localparam int DATA_W = 32;  // bus data width
  localparam int CNT_W  = 32;  // counter width
  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CSR0  = 5'h00;  // timer zero control/status
  localparam logic [ADDR_W-1:0] OFF_LOAD0 = 5'h04;  // timer zero load
  localparam logic [ADDR_W-1:0] OFF_CNT0  = 5'h08;  // timer zero counter
  localparam logic [ADDR_W-1:0] OFF_CSR1  = 5'h10;  // timer one control/status
  localparam logic [ADDR_W-1:0] OFF_LOAD1 = 5'h14;  // timer one load
  localparam logic [ADDR_W-1:0] OFF_CNT1  = 5'h18;  // timer one counter
  // -------------------------------------------------------------------------
  // control/status bit positions
  // -------------------------------------------------------------------------
  localparam int B_MODE  = 0;   // timer_mode_bit: 0 generate, 1 capture
  localparam int B_DIR   = 1;   // count_direction_bit: 1 counts down
  localparam int B_GEN   = 2;   // external generate output enable
  localparam int B_CAP   = 3;   // external capture trigger enable
  localparam int B_ARH   = 4;   // auto_reload_hold_bit
  localparam int B_LOAD  = 5;   // load counter from load register
  localparam int B_IEN   = 6;   // interrupt_enable_bit
  localparam int B_EN    = 7;   // timer enable
  localparam int B_INT   = 8;   // interrupt_status_flag
  localparam int B_PWM   = 9;   // pwm enable
  localparam int B_ALL   = 10;  // enable_all_bit
  localparam int B_CASC  = 11;  // cascade enable
  localparam int CSR_W   = 12;  // implemented control bits
  localparam logic [CSR_W-1:0] CSR_RST = 12'h000;  // control reset value
  localparam logic [1:0] RESP_OKAY = 2'h0;  // axi okay response
endpackage

// File: testbench/dtc_host.sv
// axi4-lite host model that reaches the timer block registers
`timescale 1ns/1ns
module dtc_host
  import dtc_pkg::*;
(
  input  wire logic                       aclk,
  output logic [dtc_pkg::ADDR_W-1:0]      s_axi_awaddr,
  output logic                            s_axi_awvalid,
  input  wire logic                       s_axi_awready,
  output logic [dtc_pkg::DATA_W-1:0]      s_axi_wdata,
  output logic                            s_axi_wvalid,
  input  wire logic                       s_axi_wready,
  input  wire logic [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_bvalid,
  output logic                            s_axi_bready,
  output logic [dtc_pkg::ADDR_W-1:0]      s_axi_araddr,
  output logic                            s_axi_arvalid,
  input  wire logic                       s_axi_arready,
  input  wire logic [dtc_pkg::DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]                 s_axi_rresp,
  input  wire logic                       s_axi_rvalid,
  output logic                            s_axi_rready
);
  // -------------------------------------------------------------------------
  // idle bus and word transfers
  // -------------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // word write: both channels offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;  // released address no longer shows the old value
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;  // released data no longer shows the old value
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // word read: address held until taken, data taken with rvalid
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// File: testbench/tb_dual_timer_counter_pwm.sv
// self-checking bench for the dual timer counter with pwm output
`timescale 1ns/1ns
module tb_dual_timer_counter_pwm;
  import dtc_pkg::*;
  logic              aclk, aresetn, freeze, trig0, trig1, gen0, gen1, pwm, irq, gen0_q, pwm_q;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, v, w, c, ld;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] mdl [8];  // expected word at each offset
  int                miscompares, tests_run, pulses, wide, rises, hi, lo;
  dtc_top dtc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_trigger_zero(trig0),
    .capture_trigger_one(trig1), .freeze, .generate_out_zero(gen0),
    .generate_out_one(gen1), .pulse_width_output(pwm), .interrupt(irq));
  dtc_host dtc_host_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // -------------------------------------------------------------------------
  // clock, monitors and helpers
  // -------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // pulse counts, over-long pulses and pwm duty
  always @(posedge aclk) begin
    wide += int'(gen0 && gen0_q);
    pulses += int'(gen0 && !gen0_q);
    rises += int'(pwm && !pwm_q);
    hi += int'(pwm);
    lo += int'(!pwm);
    gen0_q = gen0;
    pwm_q = pwm;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // register write through the host, model follows the load words
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    dtc_host_inst.wr(a, d, rsp);
    chk(32'(rsp), 32'(RESP_OKAY));
    if (a == OFF_LOAD0 || a == OFF_LOAD1) begin
      mdl[a[4:2]] = d;
    end
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a);
    dtc_host_inst.rd(a, v, rsp);
    chk(32'(rsp), 32'(RESP_OKAY));
  endtask
  // read one control bit and compare it
  task automatic fld(input logic [ADDR_W-1:0] a, input int b, input logic e);
    rreg(a);
    chk(32'(v[b]), 32'(e));
  endtask
  // capture pin pulse long enough for the input synchroniser
  task automatic pulse_trig;
    @(posedge aclk);
    trig0 <= 1'b1;
    repeat (4) @(posedge aclk);
    trig0 <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out;
  end
  // -------------------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    freeze = 1'b0;
    trig0 = 1'b0;
    trig1 = 1'b0;
    for (int i = 0; i < 8; i++) mdl[i] = '0;
    void'($urandom(78));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rreg(5'(i * 4));
      chk(v, mdl[i]);
    end
    // unused words ignore writes, load words keep them
    wreg(5'h0c, $urandom);
    wreg(5'h1c, $urandom);
    wreg(OFF_LOAD0, $urandom);
    wreg(OFF_LOAD1, $urandom);
    for (int i = 1; i < 8; i += 2) begin
      rreg(5'(i * 4));
      chk(v, mdl[i]);
    end
    // one-shot generate: up with interrupt enabled, then down with it masked
    for (int k = 0; k < 2; k++) begin
      ld = k ? 32'($urandom % 16) + 4 : 32'hffffffef + ($urandom % 16);
      c = 32'((k << B_DIR) | (1 << B_GEN) | ((1 - k) << B_IEN));
      wreg(OFF_LOAD0, ld);
      wreg(OFF_CSR0, c | 32'h20);
      rreg(OFF_CNT0);
      chk(v, ld);
      pulses = 0;
      wide = 0;
      wreg(OFF_CSR0, c | 32'h80);
      repeat (60) @(posedge aclk);
      chk(pulses, 1);
      chk(wide, 0);
      chk(32'(irq), 1 - k);
      fld(OFF_CSR0, B_INT, 1);
      wreg(OFF_CSR0, c | 32'h80);
      fld(OFF_CSR0, B_INT, 1);
      wreg(OFF_CSR0, c | 32'h180);
      fld(OFF_CSR0, B_INT, 0);
      chk(32'(irq), 0);
    end
    // auto-reload keeps pulsing, freeze stops the count
    ld = 32'hfffffff8;
    wreg(OFF_LOAD0, ld);
    wreg(OFF_CSR0, 32'h34);
    pulses = 0;
    wide = 0;
    wreg(OFF_CSR0, 32'h94);
    repeat (100) @(posedge aclk);
    chk(32'(pulses > 8), 1);
    chk(wide, 0);
    rreg(OFF_CNT0);
    chk(32'(v >= ld), 1);
    freeze <= 1'b1;
    repeat (4) @(posedge aclk);
    rreg(OFF_CNT0);
    w = v;
    repeat (20) @(posedge aclk);
    rreg(OFF_CNT0);
    chk(v, w);
    freeze <= 1'b0;
    wreg(OFF_CSR0, 32'h100);
    // capture: hold keeps the first value, overwrite takes the new one
    wreg(OFF_LOAD0, 0);
    wreg(OFF_CSR0, 32'h20);
    wreg(OFF_CSR0, 32'h89);
    rreg(OFF_CNT0);
    c = v;
    pulse_trig;
    rreg(OFF_LOAD0);
    w = v;
    chk(32'(w > c && w - c < 64), 1);
    fld(OFF_CSR0, B_INT, 1);
    pulse_trig;
    rreg(OFF_LOAD0);
    chk(v, w);
    wreg(OFF_CSR0, 32'h99);
    pulse_trig;
    rreg(OFF_LOAD0);
    chk(32'(v > w), 1);
    wreg(OFF_CSR0, 32'h100);
    // enable-all sets both enables, clearing it leaves them
    wreg(OFF_CSR0, 32'h400);
    fld(OFF_CSR0, B_EN, 1);
    fld(OFF_CSR1, B_EN, 1);
    wreg(OFF_CSR0, 32'h80);
    fld(OFF_CSR0, B_ALL, 0);
    fld(OFF_CSR1, B_EN, 1);
    wreg(OFF_CSR0, 0);
    wreg(OFF_CSR1, 0);
    // cascade: upper half steps once on the lower wrap
    ld = $urandom & 32'hffff;
    wreg(OFF_LOAD0, 32'hfffffffc);
    wreg(OFF_LOAD1, ld);
    wreg(OFF_CSR0, 32'h820);
    wreg(OFF_CSR0, 32'h880);
    repeat (30) @(posedge aclk);
    rreg(OFF_CNT1);
    chk(v, ld + 1);
    rreg(OFF_CNT0);
    chk(32'(v < 64), 1);
    wreg(OFF_CSR0, 0);
    // pwm: long period on timer zero, short high time on timer one
    wreg(OFF_LOAD0, 40);
    wreg(OFF_LOAD1, 10);
    wreg(OFF_CSR1, 32'h36);
    wreg(OFF_CSR1, 32'h16);
    wreg(OFF_CSR0, 32'h236);
    hi = 0;
    lo = 0;
    rises = 0;
    wreg(OFF_CSR0, 32'h616);
    repeat (400) @(posedge aclk);
    chk(32'(rises > 5), 1);
    chk(32'(hi > 0 && hi < lo), 1);
    // reset in mid-run drops every timer output and the timer zero pwm enable bit
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'({pwm, irq, gen0, gen1}), 0);
    aresetn <= 1'b1;
    fld(OFF_CSR0, B_PWM, 0);
    close_out;
  end
endmodule
